// *** common/itv_pkg.sv ***
// constants, layouts and types shared by the interrupt and trap vectoring block
package itv_pkg;

    // peripheral interrupt nodes in table order
    localparam int ITV_NODES  = 20;
    localparam int ITV_NODE_W = 5;
    // trap number per node; the vector location is four times this
    localparam logic [6:0] ITV_NODE_TRAP [0:ITV_NODES-1] = '{
        7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
        7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,
        7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F};
    // nodes of the second timer module, fuller variant only
    localparam logic [ITV_NODES-1:0] ITV_FULL_ONLY = 20'h01C00;

    // node control register layout
    localparam int ITV_CTL_LVL_LSB = 0;
    localparam int ITV_CTL_IE_BIT  = 6;
    localparam int ITV_CTL_IR_BIT  = 7;

    // exception causes, index = bit in the exception_flag_register
    localparam int ITV_EXC_N       = 8;
    localparam int ITV_EXC_NMI     = 0;
    localparam int ITV_EXC_STACK_OVERRUN_FLAG   = 1;
    localparam int ITV_EXC_STACK_UNDERRUN_FLAG   = 2;
    localparam int ITV_EXC_UNKNOWN_OPCODE_FLAG  = 3;
    localparam int ITV_EXC_PROTECTED_INSTR_FAULT_FLAG  = 4;
    localparam int ITV_EXC_ODDWORD = 5;
    localparam int ITV_EXC_ODDFTCH = 6;
    localparam int ITV_EXC_NOEXTB  = 7;
    localparam logic [6:0] ITV_EXC_TRAP [0:ITV_EXC_N-1] = '{
        7'h02, 7'h04, 7'h06, 7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A};
    // trap priority: class A above class B
    localparam logic [1:0] ITV_EXC_PRIO [0:ITV_EXC_N-1] = '{
        2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
    localparam logic [6:0] ITV_RESET_TRAP = 7'h00;
    localparam logic [3:0] ITV_TRAP_LEVEL = 4'hF;

    // register byte offsets, and the exception flag register reset value
    localparam logic [7:0] ITV_OFS_NODE0  = 8'h00;
    localparam logic [7:0] ITV_OFS_EXC    = 8'h80;
    localparam logic [7:0] ITV_OFS_STATUS = 8'h84;
    localparam logic [7:0] ITV_EXC_RST    = 8'h00;

    localparam logic [1:0] ITV_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ITV_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ITV_K_RESET = 2'b00,
        ITV_K_TRAP  = 2'b01,
        ITV_K_SWTRP = 2'b10,
        ITV_K_NODE  = 2'b11
    } itv_kind_t;

    // redirection offered to the core
    typedef struct packed {
        itv_kind_t  kind;
        logic [3:0] level;
        logic [6:0] trap_num;
        logic [8:0] vec_addr;
    } itv_vec_t;

    typedef enum logic [0:0] {
        ITV_S_IDLE  = 1'b0,
        ITV_S_OFFER = 1'b1
    } itv_fsm_t;

endpackage : itv_pkg

// *** design/itv_ctrl.sv ***
// interrupt and trap vectoring controller with an AXI4-Lite register port
//
// Function
// - each node has request, enable, vector and trap number; inputs 1-7 use 19h-1Fh.
// - second timer module nodes exist only in the fuller variant.
// - a hardware exception redirects the core at once, unmaskable.
// - each hardware exception sets its own bit in the exception flag register.
// - an exception preempts anything except a trap service of equal or higher priority.
// - standard and event transfer requests wait while a trap service runs.
// - nonmaskable, stack overrun and underrun use 08h, 10h, 18h, traps 02h-06h.
// - the five class B causes share vector 28h, trap 0Ah, told apart by flag.
// - each node control register holds a sixteen level priority field.
// - an accepted service is interrupted only by a strictly higher level.
// - software setting a node request flag raises that node's request.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module itv_ctrl import itv_pkg::*; #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int ADDR_W       = 8
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [ITV_NODES-1:0] node_event_i,
    input  wire logic [ITV_EXC_N-1:0] exc_event_i,
    input  wire logic                 sw_trap_i,
    input  wire logic [6:0]           sw_trap_num_i,
    input  wire logic                 sw_reset_i,
    input  wire logic                 wdt_overflow_i,
    input  wire logic [3:0]           core_level_i,
    input  wire logic                 core_ack_i,
    input  wire logic                 core_done_i,
    output itv_vec_t                  vec_o,
    output logic                      vec_valid_o,
    output logic                      pec_hold_o
);
    if (ADDR_W != 8) begin : g_chk
        $error("itv_ctrl: ADDR_W must be 8");
    end

    typedef struct packed {
        logic                 aw_have;
        logic [7:0]           aw_addr;
        logic                 w_have;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [ITV_EXC_N-1:0] exc_flags;
        logic [ITV_EXC_N-1:0] trap_pend;
        logic                 sw_pend;
        logic [6:0]           sw_num;
        logic                 reset_pend;
        logic                 trap_active;
        logic [1:0]           trap_prio;
        itv_fsm_t             fsm;
        itv_vec_t             vec;
        logic [ITV_NODE_W-1:0] node_idx;
    } itv_state_t;

    itv_state_t st;
    itv_state_t next_st;

    logic [ITV_NODES-1:0] node_req;
    logic [ITV_NODES-1:0] node_en;
    logic [3:0]           node_lvl [0:ITV_NODES-1];
    logic [ITV_NODES-1:0] node_wr;
    logic [ITV_NODES-1:0] node_clr;

    ////////////////////////////////////////////////////////////////////////
    // nodes of the second timer module vanish in the reduced variant
    for (genvar g = 0; g < ITV_NODES; g++) begin : g_node
        itv_node #(
            .PRESENT (FULL_VARIANT || !ITV_FULL_ONLY[g])
        ) u_node (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .hw_set_i   (node_event_i[g]),
            .hw_clr_i   (node_clr[g]),
            .wr_en_i    (node_wr[g]),
            .wr_data_i  (st.wdata[7:0]),
            .req_o      (node_req[g]),
            .en_o       (node_en[g]),
            .lvl_o      (node_lvl[g])
        );
    end

    logic                  wr_go;
    logic                  wr_node;
    logic [ITV_NODE_W-1:0] wr_idx;
    logic [ITV_NODE_W-1:0] rd_idx;
    logic                  rd_node;

    assign wr_go   = st.aw_have && st.w_have && !st.bvalid;
    assign wr_idx  = st.aw_addr[ITV_NODE_W+1:2];
    assign wr_node = !st.aw_addr[7] && (32'(wr_idx) < ITV_NODES);
    assign rd_idx  = s_axi_araddr[ITV_NODE_W+1:2];
    assign rd_node = !s_axi_araddr[7] && (32'(rd_idx) < ITV_NODES);

    always_comb begin
        for (int i = 0; i < ITV_NODES; i++) begin
            node_wr[i]  = wr_go && wr_node && st.wstrb[0]
                          && (32'(wr_idx) == i);
            node_clr[i] = (st.fsm == ITV_S_OFFER) && core_ack_i
                          && (st.vec.kind == ITV_K_NODE)
                          && (32'(st.node_idx) == i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic                  best_ok;
        logic [3:0]            best_lvl;
        logic [ITV_NODE_W-1:0] best_idx;
        logic                  t_ok;
        int                    t_idx;
        logic                  rst_evt;
        best_ok  = 1'b0;
        best_lvl = 4'h0;
        best_idx = '0;
        t_ok     = 1'b0;
        t_idx    = 0;
        rst_evt  = sw_reset_i || wdt_overflow_i;
        next_st  = st;

        // AXI write: address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_have = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (wr_go) begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = ITV_RESP_OKAY;
            if (st.aw_addr == ITV_OFS_EXC) begin
                if (st.wstrb[0]) begin
                    next_st.exc_flags = st.exc_flags & ~st.wdata[7:0];
                end
            end else if (!wr_node) begin
                next_st.bresp = ITV_RESP_SLVERR;
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_have && !next_st.bvalid;
        next_st.wready  = !next_st.w_have && !next_st.bvalid;

        // AXI read: data registered one cycle after the address
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = ITV_RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            if (rd_node) begin
                next_st.rdata[ITV_CTL_IR_BIT]         = node_req[rd_idx];
                next_st.rdata[ITV_CTL_IE_BIT]         = node_en[rd_idx];
                next_st.rdata[ITV_CTL_LVL_LSB +: 4]   = node_lvl[rd_idx];
            end else if (s_axi_araddr == ITV_OFS_EXC) begin
                next_st.rdata[ITV_EXC_N-1:0] = st.exc_flags;
            end else if (s_axi_araddr == ITV_OFS_STATUS) begin
                next_st.rdata[0]    = st.trap_active;
                next_st.rdata[2:1]  = st.trap_prio;
                next_st.rdata[3]    = st.fsm == ITV_S_OFFER;
                next_st.rdata[14:8] = st.vec.trap_num;
            end else begin
                next_st.rresp = ITV_RESP_SLVERR;
            end
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;

        // flag per cause, set wins over the software clear
        next_st.exc_flags = next_st.exc_flags | exc_event_i;
        if (!st.sw_pend && sw_trap_i) begin
            next_st.sw_pend = 1'b1;
            next_st.sw_num  = sw_trap_num_i;
        end

        // highest enabled node level; ties go to the lower node index
        for (int i = 0; i < ITV_NODES; i++) begin
            if (node_req[i] && node_en[i]
                && (!best_ok || node_lvl[i] > best_lvl)) begin
                best_ok  = 1'b1;
                best_lvl = node_lvl[i];
                best_idx = ITV_NODE_W'(i);
            end
        end
        for (int i = ITV_EXC_N - 1; i >= 0; i--) begin
            if (st.trap_pend[i]) begin
                t_ok  = 1'b1;
                t_idx = i;
            end
        end

        case (st.fsm)
            ITV_S_IDLE: begin
                next_st.fsm = ITV_S_OFFER;
                if (st.reset_pend) begin
                    next_st.vec.kind     = ITV_K_RESET;
                    next_st.vec.level    = ITV_TRAP_LEVEL;
                    next_st.vec.trap_num = ITV_RESET_TRAP;
                end else if (t_ok && (!st.trap_active
                             || ITV_EXC_PRIO[t_idx] > st.trap_prio)) begin
                    next_st.vec.kind     = ITV_K_TRAP;
                    next_st.vec.level    = ITV_TRAP_LEVEL;
                    next_st.vec.trap_num = ITV_EXC_TRAP[t_idx];
                    next_st.node_idx     = ITV_NODE_W'(t_idx);
                end else if (st.sw_pend && !st.trap_active) begin
                    next_st.vec.kind     = ITV_K_SWTRP;
                    next_st.vec.level    = core_level_i;
                    next_st.vec.trap_num = st.sw_num;
                end else if (best_ok && !st.trap_active
                             && best_lvl > core_level_i) begin
                    next_st.vec.kind     = ITV_K_NODE;
                    next_st.vec.level    = best_lvl;
                    next_st.vec.trap_num = ITV_NODE_TRAP[best_idx];
                    next_st.node_idx     = best_idx;
                end else begin
                    next_st.fsm = ITV_S_IDLE;
                end
                // vector is four times the trap number
                next_st.vec.vec_addr = {next_st.vec.trap_num, 2'b00};
            end
            ITV_S_OFFER: begin
                if (core_ack_i) begin
                    next_st.fsm = ITV_S_IDLE;
                    case (st.vec.kind)
                        ITV_K_RESET: next_st.reset_pend = 1'b0;
                        ITV_K_SWTRP: next_st.sw_pend = 1'b0;
                        ITV_K_TRAP: begin
                            next_st.trap_pend[st.node_idx[2:0]] = 1'b0;
                            next_st.trap_active = 1'b1;
                            next_st.trap_prio   =
                                ITV_EXC_PRIO[st.node_idx[2:0]];
                        end
                        default: ;
                    endcase
                end
            end
            default: next_st.fsm = ITV_S_IDLE;
        endcase

        // single trap level tracked: a return ends all trap service
        if (core_done_i) begin
            next_st.trap_active = 1'b0;
            next_st.trap_prio   = 2'h0;
        end
        next_st.trap_pend = next_st.trap_pend | exc_event_i;
        if (rst_evt) begin
            // software reset and watchdog restart at zero
            next_st.reset_pend  = 1'b1;
            next_st.trap_active = 1'b0;
            next_st.trap_prio   = 2'h0;
            next_st.fsm         = ITV_S_IDLE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st            <= '0;
            st.reset_pend <= 1'b1;
            st.exc_flags  <= ITV_EXC_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign vec_o         = st.vec;
    assign vec_valid_o   = st.fsm == ITV_S_OFFER;
    assign pec_hold_o    = st.trap_active;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_ext1;
        vec_valid_o && vec_o.kind == ITV_K_NODE && st.node_idx == 5'h00
        |-> vec_o.trap_num == 7'h19 && vec_o.vec_addr == 9'h064;
    endproperty
    a_ext1: assert property (p_ext1)
        else $error("first external input misvectored");

    property p_nmi;
        exc_event_i[ITV_EXC_NMI] && !vec_valid_o && !st.trap_active
        && !st.reset_pend && !sw_reset_i && !wdt_overflow_i
        && st.trap_pend == '0 && next_st.fsm == ITV_S_IDLE
        |-> ##2 vec_valid_o && vec_o.trap_num == 7'h02
        && vec_o.vec_addr == 9'h008;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("nonmaskable event not vectored in two cycles");

    property p_flag;
        exc_event_i[ITV_EXC_STACK_OVERRUN_FLAG] |=> st.exc_flags[ITV_EXC_STACK_OVERRUN_FLAG];
    endproperty
    a_flag: assert property (p_flag)
        else $error("stack overrun flag not set");

    property p_preempt;
        $rose(vec_valid_o) && vec_o.kind == ITV_K_TRAP && $past(st.trap_active)
        |-> ITV_EXC_PRIO[st.node_idx[2:0]] > $past(st.trap_prio);
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("trap preempted an equal or higher trap");

    property p_trap_block;
        $rose(vec_valid_o) && $past(st.trap_active)
        |-> vec_o.kind != ITV_K_NODE;
    endproperty
    a_trap_block: assert property (p_trap_block)
        else $error("node request offered during trap service");

    property p_classb;
        $rose(vec_valid_o) && vec_o.kind == ITV_K_TRAP
        && st.node_idx >= 5'(ITV_EXC_UNKNOWN_OPCODE_FLAG)
        |-> vec_o.trap_num == 7'h0A && vec_o.vec_addr == 9'h028;
    endproperty
    a_classb: assert property (p_classb)
        else $error("class B cause misvectored");

    property p_higher;
        $rose(vec_valid_o) && vec_o.kind == ITV_K_NODE
        |-> vec_o.level > $past(core_level_i);
    endproperty
    a_higher: assert property (p_higher)
        else $error("node offered at or below the CPU level");

    property p_times4;
        vec_valid_o |-> vec_o.vec_addr == {vec_o.trap_num, 2'b00};
    endproperty
    a_times4: assert property (p_times4)
        else $error("vector is not four times the trap number");

    property p_reset_vec;
        $fell(rst_i) |=> vec_valid_o && vec_o.kind == ITV_K_RESET
        && vec_o.vec_addr == 9'h000 && st.exc_flags == $past(st.exc_flags);
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset did not start at vector zero");

    property p_hold;
        vec_valid_o && !core_ack_i && !sw_reset_i && !wdt_overflow_i
        |=> vec_valid_o && $stable(vec_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("offer changed before acknowledge");

    c_node: cover property ($rose(vec_valid_o) && vec_o.kind == ITV_K_NODE);
    c_nest: cover property (st.trap_active && $rose(vec_valid_o));
    c_swtrp: cover property (vec_valid_o && vec_o.kind == ITV_K_SWTRP);
    c_write: cover property (st.bvalid && s_axi_bready);

endmodule : itv_ctrl

// *** design/itv_node.sv ***
// one interrupt node: request flag, enable flag and priority level
`timescale 1ns/1ps
module itv_node import itv_pkg::*; #(
    parameter bit PRESENT = 1'b1
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       hw_set_i,
    input  wire logic       hw_clr_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_data_i,
    output logic            req_o,
    output logic            en_o,
    output logic [3:0]      lvl_o
);
    typedef struct packed {
        logic       req;
        logic       en;
        logic [3:0] lvl;
    } itv_node_t;

    itv_node_t st;
    itv_node_t next_st;

    always_comb begin
        next_st = st;
        // acknowledge clear goes first so a software set in that cycle wins
        if (hw_clr_i) begin
            next_st.req = 1'b0;
        end
        if (wr_en_i) begin
            next_st.en  = wr_data_i[ITV_CTL_IE_BIT];
            next_st.lvl = wr_data_i[ITV_CTL_LVL_LSB +: 4];
            next_st.req = wr_data_i[ITV_CTL_IR_BIT];
        end
        // an event in the clearing cycle is kept
        if (hw_set_i) begin
            next_st.req = 1'b1;
        end
        if (!PRESENT) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign req_o = st.req;
    assign en_o  = st.en;
    assign lvl_o = st.lvl;

    ////////////////////////////////////////////////////////////////////////
    property p_sw_set;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_en_i && wr_data_i[ITV_CTL_IR_BIT] |=> req_o == PRESENT;
    endproperty
    a_sw_set: assert property (p_sw_set)
        else $error("software set of request flag lost");

    property p_level;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_en_i && PRESENT |=> lvl_o == $past(wr_data_i[3:0]);
    endproperty
    a_level: assert property (p_level)
        else $error("priority level not taken from write");

    property p_absent;
        @(posedge core_clk_i) disable iff (rst_i)
        !PRESENT |-> ##1 !req_o && !en_o;
    endproperty
    a_absent: assert property (p_absent)
        else $error("absent node shows a request");

endmodule : itv_node

// *** tb/itv_core_model.sv ***
// core side model: takes vector offers and returns from trap services
`timescale 1ns/1ps
module itv_core_model import itv_pkg::*; (
    input  wire logic     core_clk_i,
    input  wire logic     rst_i,
    input  wire itv_vec_t vec_i,
    input  wire logic     vec_valid_i,
    input  wire logic     done_en_i,
    output logic          ack_o,
    output logic          done_o
);
    logic [1:0] cnt;
    logic       slow, trap;
    // every other offer is taken late
    always @(posedge core_clk_i) begin
        {ack_o, done_o} <= 2'h0;
        if (rst_i) begin
            {cnt, slow, trap} <= 4'h0;
        end else if (vec_valid_i && !ack_o) begin
            cnt <= cnt + 2'h1;
            if (cnt >= {slow, slow}) begin
                {ack_o, cnt, slow} <= {3'h4, !slow};
                trap <= trap | (vec_i.kind == ITV_K_TRAP);
            end
        end else if (trap && done_en_i && !ack_o) begin
            {done_o, trap} <= 2'h2;
        end
    end
endmodule : itv_core_model

// *** tb/tb.sv ***
// bench for the vectoring controller
`timescale 1ns/1ps
module tb;
import itv_pkg::*;
logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0;
logic arv = 1'h0, rry = 1'h0, swt = 1'h0, swr = 1'h0, wdt = 1'h0;
logic den = 1'h1, awr, wrr, bv, arr, rv, ack, done, vv, hold;
logic [1:0] brs, rrs;
logic [3:0] lvl = 4'h0, l;
logic [6:0] swn = 7'h00;
logic [7:0] awa = 8'h00, ara = 8'h00, exc = 8'h00;
logic [19:0] nev = 20'h0;
logic [31:0] wd = 32'h0, rdat, seed = 32'h3D;
itv_vec_t vec, ev, q[$];
int bad_count = 0, n_tests = 0, i;
always #20 clk = ~clk;
itv_ctrl u_itv_ctrl (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr(awa),
.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr),
.s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry),
.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
.s_axi_rdata(rdat), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
.s_axi_rready(rry), .node_event_i(nev), .exc_event_i(exc),
.sw_trap_i(swt), .sw_trap_num_i(swn), .sw_reset_i(swr),
.wdt_overflow_i(wdt), .core_level_i(lvl), .core_ack_i(ack),
.core_done_i(done), .vec_o(vec), .vec_valid_o(vv), .pec_hold_o(hold));
itv_core_model u_itv_core_model (.core_clk_i(clk), .rst_i(rst),
.vec_i(vec), .vec_valid_i(vv), .done_en_i(den), .ack_o(ack), .done_o(done));
function automatic logic [31:0] rnd();
seed ^= seed << 13;
seed ^= seed >> 17;
seed ^= seed << 5;
return seed;
endfunction : rnd
function automatic itv_vec_t mk(itv_kind_t k, logic [3:0] v, logic [6:0] t);
return '{k, v, t, {t, 2'h0}};
endfunction : mk
task automatic chk(input logic [31:0] g, e);
n_tests++;
if (g !== e) begin
bad_count++;
$display("unexpected at %0t: got %h want %h", $time, g, e);
end
endtask : chk
task automatic wr(input logic [7:0] a, input logic [31:0] d, logic [1:0] r);
logic ta, tw;
int n;
{ta, tw} = 2'h0;
@(posedge clk) {awa, wd, awv, wv, bry} <= {a, d, 3'h7};
for (n = 0; n < 99 && !(ta && tw); n++) begin
@(negedge clk);
{ta, tw} = {ta | awr & awv, tw | wrr & wv};
@(posedge clk) {awv, wv} <= {awv & !ta, wv & !tw};
end
for (n = 0; n < 99 && bv !== 1'h1; n++) @(negedge clk);
chk(32'(brs), 32'(r));
@(posedge clk) bry <= 1'h0;
endtask : wr
task automatic rd(input logic [7:0] a, input logic [31:0] d, logic [1:0] r);
int n;
@(posedge clk) {ara, arv, rry} <= {a, 2'h3};
@(negedge clk);
for (n = 0; n < 99 && arr !== 1'h1; n++) @(negedge clk);
@(posedge clk) arv <= 1'h0;
for (n = 0; n < 99 && rv !== 1'h1; n++) @(negedge clk);
chk(rdat, d);
chk(32'(rrs), 32'(r));
@(posedge clk) rry <= 1'h0;
endtask : rd
task automatic drain();
int n;
for (n = 0; n < 99 && q.size() != 0; n++) @(posedge clk);
repeat (3) @(negedge clk);
chk(32'(q.size()), 32'h0);
endtask : drain
task automatic kick(input logic [30:0] v);
@(posedge clk) {nev, exc, swr, wdt, swt} <= v;
@(posedge clk) {nev, exc, swr, wdt, swt} <= 31'h0;
endtask : kick
task automatic test_done();
$display("checks %0d mismatches %0d", n_tests, bad_count);
if (bad_count == 0 && n_tests > 0)
$display("No errors found");
else
$display("Errors were found");
$finish;
endtask : test_done
// accepted offer against oldest note
always @(negedge clk) begin
if (vv === 1'h1 && ack === 1'h1) begin
ev = q.size() != 0 ? q.pop_front() : '1;
chk(32'({vec.kind, vec.trap_num, vec.vec_addr}),
32'({ev.kind, ev.trap_num, ev.vec_addr}));
if (ev.kind != ITV_K_RESET) chk(32'(vec.level), 32'(ev.level));
end
end
initial begin
#800000;
bad_count++;
test_done();
end
initial begin
repeat (2) @(posedge clk);
rst <= 1'h0;
q.push_back(mk(ITV_K_RESET, 4'h0, ITV_RESET_TRAP));
drain();
for (i = 0; i < ITV_EXC_N; i++) begin
q.push_back(mk(ITV_K_TRAP, ITV_TRAP_LEVEL, ITV_EXC_TRAP[i]));
kick(31'h8 << i);
drain();
rd(ITV_OFS_EXC, 32'h1 << i, ITV_RESP_OKAY);
wr(ITV_OFS_EXC, 32'h1 << i, ITV_RESP_OKAY);
end
$display("test traps done");
for (i = 0; i < ITV_NODES; i++) begin
l = 4'(rnd() % 15) + 4'h1;
q.push_back(mk(ITV_K_NODE, l, ITV_NODE_TRAP[i]));
wr(8'(4 * i), 32'({i[0], 3'h4, l}), ITV_RESP_OKAY);
if (!i[0]) kick(31'h800 << i);
drain();
rd(8'(4 * i), 32'({4'h4, l}), ITV_RESP_OKAY);
end
$display("test nodes done");
@(posedge clk) lvl <= 4'h5;
wr(8'h00, 32'hC5, ITV_RESP_OKAY);
repeat (4) @(negedge clk);
chk(32'(vv), 32'h0);
q.push_back(mk(ITV_K_NODE, 4'h6, ITV_NODE_TRAP[1]));
wr(8'h04, 32'hC6, ITV_RESP_OKAY);
drain();
q.push_back(mk(ITV_K_NODE, 4'h5, ITV_NODE_TRAP[0]));
@(posedge clk) lvl <= 4'h3;
drain();
$display("test levels done");
for (i = 0; i < 4; i++) begin
@(posedge clk) swn <= i == 0 ? 7'h7F : 7'(rnd());
@(negedge clk) q.push_back(mk(ITV_K_SWTRP, 4'h3, swn));
kick(31'h1);
drain();
end
$display("test software traps done");
@(posedge clk) {lvl, den} <= 5'h0;
q.push_back(mk(ITV_K_TRAP, ITV_TRAP_LEVEL, 7'h0A));
kick(31'h40);
drain();
wr(8'h00, 32'hC9, ITV_RESP_OKAY);
q.push_back(mk(ITV_K_TRAP, ITV_TRAP_LEVEL, 7'h02));
kick(31'h8);
drain();
chk(32'({hold, vv}), 32'h2);
q.push_back(mk(ITV_K_NODE, 4'h9, ITV_NODE_TRAP[0]));
@(posedge clk) den <= 1'h1;
drain();
wr(ITV_OFS_EXC, 32'h9, ITV_RESP_OKAY);
$display("test nesting done");
for (i = 1; i < 3; i++) begin
q.push_back(mk(ITV_K_RESET, 4'h0, ITV_RESET_TRAP));
kick(31'(i * 2));
drain();
end
@(posedge clk) rst <= 1'h1;
repeat (2) @(posedge clk);
rst <= 1'h0;
q.push_back(mk(ITV_K_RESET, 4'h0, ITV_RESET_TRAP));
drain();
rd(ITV_OFS_EXC, 32'h0, ITV_RESP_OKAY);
wr(8'h60, 32'hFF, ITV_RESP_SLVERR);
rd(8'h60, 32'h0, ITV_RESP_SLVERR);
$display("test resets done");
test_done();
end
endmodule : tb
